// file: design/clk_pwr_pkg.sv
package clk_pwr_pkg;

  // Register offsets
  localparam logic [7:0] CPU_MODE_ADDR = 8'h00;
  localparam logic [7:0] CLK_STATUS_ADDR = 8'h01;

  // CPU mode register fields
  localparam int SUB_OSC_CTRL_A_BIT = 4;
  localparam int SUB_OSC_CTRL_B_BIT = 5;
  localparam int MAIN_OSC_HALT_BIT = 6;
  localparam int CPU_CLOCK_SOURCE_SELECT_BIT = 7;
  localparam logic [7:0] CPU_MODE_RESET = 8'h00;
  localparam logic [7:0] CPU_MODE_MASK = 8'hf0;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CPU_CLOCK_BIT = 2;
  localparam int ST_ACTIVE_SUB_BIT = 3;
  localparam int ST_MAIN_RUN_BIT = 4;
  localparam int ST_SUB_RUN_BIT = 5;
  localparam int ST_WARMUP_BIT = 6;

  // Warm-up chain loads and prescale
  localparam logic [7:0] TIMER3_LOAD = 8'hff;
  localparam logic [7:0] TIMER4_LOAD = 8'h07;
  localparam logic [3:0] PRESCALE_LAST = 4'hf;

  // Interrupt request positions
  localparam int IRQ_COUNT = 9;
  localparam int IRQ_EXT_A = 0;
  localparam int IRQ_EXT_B = 1;
  localparam int IRQ_COUNTER = 2;
  localparam int IRQ_TIMER1 = 3;
  localparam int IRQ_TIMER2 = 4;
  localparam int IRQ_TIMER3 = 5;
  localparam int IRQ_TIMER4 = 6;
  localparam int IRQ_SERIAL = 7;
  localparam int IRQ_KEY = 8;
  localparam logic [8:0] WAIT_WAKE_MASK = 9'h1ff;
  localparam logic [8:0] STOP_WAKE_MASK = 9'h19f;

  // Power states, Gray coded in the order run-wait-stop-warmup-run
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP = 2'b11,
    PWR_WARMUP = 2'b10
  } pwr_state_t;

endpackage

// file: design/osc_pin_sync.sv
module osc_pin_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Oscillator pins
  input wire logic [1:0] i_pin,
  // Filtered levels and rising-edge pulses
  output logic [1:0] o_level,
  output logic [1:0] o_rise
);

  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;
  logic [1:0] next_level;
  logic [1:0] next_rise;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_bit
      // Accept a new level only when the last two stages agree
      always_comb
      begin
        next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : o_level[g];
        next_rise[g] = next_level[g] & ~o_level[g];
      end
    end
  endgenerate

  // Three-stage synchroniser and filtered outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
      stage3 <= 2'h0;
      o_level <= 2'h0;
      o_rise <= 2'h0;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      o_level <= next_level;
      o_rise <= next_rise;
    end
  end

endmodule

// file: design/warmup_chain.sv
module warmup_chain (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_load,
  input wire logic i_count_en,
  input wire logic i_osc_tick,
  // Counter state
  output logic [7:0] o_timer3,
  output logic [7:0] o_timer4,
  output logic o_overflow
);

  logic [3:0] prescale;
  logic [3:0] next_prescale;
  logic [7:0] next_timer3;
  logic [7:0] next_timer4;
  logic next_overflow;

  // Source/16 into timer 3, timer 3 underflow into timer 4
  always_comb
  begin
    next_prescale = prescale;
    next_timer3 = o_timer3;
    next_timer4 = o_timer4;
    next_overflow = 1'b0;
    if (i_load)
    begin
      next_prescale = 4'h0;
      next_timer3 = clk_pwr_pkg::TIMER3_LOAD;
      next_timer4 = clk_pwr_pkg::TIMER4_LOAD;
    end
    else if (i_count_en && i_osc_tick)
    begin
      next_prescale = prescale + 4'h1;
      if (prescale == clk_pwr_pkg::PRESCALE_LAST)
      begin
        next_timer3 = o_timer3 - 8'h01;
        if (o_timer3 == 8'h00)
        begin
          next_timer4 = o_timer4 - 8'h01;
          next_overflow = (o_timer4 == 8'h00);
        end
      end
    end
  end

  // Counter registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      prescale <= 4'h0;
      o_timer3 <= 8'h00;
      o_timer4 <= 8'h00;
      o_overflow <= 1'b0;
    end
    else
    begin
      prescale <= next_prescale;
      o_timer3 <= next_timer3;
      o_timer4 <= next_timer4;
      o_overflow <= next_overflow;
    end
  end

endmodule

// file: design/dual_osc_clock_power_control.sv
// Function
// - The CPU clock is the main oscillator divided by two unless another source is chosen.
// - With the source-select bit 7 set, the CPU clock is the sub oscillator divided by two.
// - The stop instruction halts both oscillators and freezes the CPU clock high.
// - Entering stop loads the warm-up chain with 8'hff in timer 3 and 8'h07 in timer 4.
// - A waking interrupt in stop restarts oscillation and keeps the CPU clock high until timer 4 overflows.
// - The wait instruction freezes the CPU clock high with the oscillators still running.
// - An interrupt in wait restores the CPU clock at once with no warm-up.
// - Setting bit 6 halts the main oscillator and clearing it restarts it.
// - Wait is released by external, counter, timer 1 to 4, serial and key requests.
// - Stop is released by the same requests except timers 3 and 4.
// - Leaving stop, the clock starts only after timer 4 overflow and execution resumes at the vector.
module dual_osc_clock_power_control (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  // Oscillator pins
  input wire logic i_main_osc_in,
  input wire logic i_sub_osc_in,
  output logic o_main_osc_run,
  output logic o_sub_osc_run,
  // CPU side
  input wire logic i_stop_instruction,
  input wire logic i_wait_instruction,
  input wire logic [8:0] i_irq_req,
  output logic o_cpu_clock,
  output logic o_resume_vector,
  output logic [8:0] o_wake_requests
);

  clk_pwr_pkg::pwr_state_t state;
  clk_pwr_pkg::pwr_state_t next_state;
  logic [7:0] cpu_mode;
  logic [7:0] next_cpu_mode;
  logic [7:0] next_rdata;
  logic active_sub;
  logic next_active_sub;
  logic next_cpu_clock;
  logic next_main_run;
  logic next_sub_run;
  logic next_resume;
  logic [8:0] next_wake;
  logic [1:0] osc_level;
  logic [1:0] osc_rise;
  logic src_tick;
  logic chain_load;
  logic [7:0] timer3;
  logic [7:0] timer4;
  logic chain_overflow;
  logic wait_wake;
  logic stop_wake;

  // Oscillator pins into the system clock domain
  osc_pin_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_pin({i_sub_osc_in, i_main_osc_in}),
    .o_level(osc_level),
    .o_rise(osc_rise)
  );

  // Rising edge of the oscillator that currently feeds the CPU clock
  assign src_tick = active_sub ? osc_rise[1] : osc_rise[0];
  assign chain_load = (state == clk_pwr_pkg::PWR_RUN) && i_stop_instruction;
  assign wait_wake = |(i_irq_req & clk_pwr_pkg::WAIT_WAKE_MASK);
  assign stop_wake = |(i_irq_req & clk_pwr_pkg::STOP_WAKE_MASK);

  // Timer 3 cascaded into timer 4 as the warm-up counter
  warmup_chain u_chain (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_load(chain_load),
    .i_count_en(state == clk_pwr_pkg::PWR_WARMUP),
    .i_osc_tick(src_tick),
    .o_timer3(timer3),
    .o_timer4(timer4),
    .o_overflow(chain_overflow)
  );

  // Power state sequencing and wake capture
  always_comb
  begin
    next_state = state;
    next_resume = 1'b0;
    next_wake = o_wake_requests;
    unique case (state)
      clk_pwr_pkg::PWR_RUN:
      begin
        if (i_stop_instruction)
          next_state = clk_pwr_pkg::PWR_STOP;
        else if (i_wait_instruction)
          next_state = clk_pwr_pkg::PWR_WAIT;
      end
      clk_pwr_pkg::PWR_WAIT:
      begin
        if (wait_wake)
        begin
          next_state = clk_pwr_pkg::PWR_RUN;
          next_resume = 1'b1;
          next_wake = i_irq_req;
        end
      end
      clk_pwr_pkg::PWR_STOP:
      begin
        if (stop_wake)
        begin
          next_state = clk_pwr_pkg::PWR_WARMUP;
          next_wake = i_irq_req & clk_pwr_pkg::STOP_WAKE_MASK;
        end
      end
      clk_pwr_pkg::PWR_WARMUP:
      begin
        if (chain_overflow)
        begin
          next_state = clk_pwr_pkg::PWR_RUN;
          next_resume = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state <= clk_pwr_pkg::PWR_RUN;
      o_resume_vector <= 1'b0;
      o_wake_requests <= 9'h000;
    end
    else
    begin
      state <= next_state;
      o_resume_vector <= next_resume;
      o_wake_requests <= next_wake;
    end
  end

  // CPU clock divider, freeze and source switch
  // A switch takes the place of the falling toggle at the end of a full high phase,
  // so the high phase runs on until the new source rises and no phase is ever cut
  always_comb
  begin
    next_active_sub = active_sub;
    next_cpu_clock = o_cpu_clock;
    if (src_tick)
    begin
      if (state != clk_pwr_pkg::PWR_RUN)
        next_cpu_clock = 1'b1;
      else if (o_cpu_clock && (active_sub != cpu_mode[clk_pwr_pkg::CPU_CLOCK_SOURCE_SELECT_BIT]))
        next_active_sub = cpu_mode[clk_pwr_pkg::CPU_CLOCK_SOURCE_SELECT_BIT];
      else
        next_cpu_clock = ~o_cpu_clock;
    end
  end

  // Oscillator run controls, stopped in stop once the CPU clock sits high
  always_comb
  begin
    next_main_run = ~cpu_mode[clk_pwr_pkg::MAIN_OSC_HALT_BIT];
    next_sub_run = cpu_mode[clk_pwr_pkg::SUB_OSC_CTRL_A_BIT]
      & cpu_mode[clk_pwr_pkg::SUB_OSC_CTRL_B_BIT];
    if ((next_state == clk_pwr_pkg::PWR_STOP) && next_cpu_clock)
    begin
      next_main_run = 1'b0;
      next_sub_run = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      active_sub <= 1'b0;
      o_cpu_clock <= 1'b1;
      o_main_osc_run <= 1'b1;
      o_sub_osc_run <= 1'b0;
    end
    else
    begin
      active_sub <= next_active_sub;
      o_cpu_clock <= next_cpu_clock;
      o_main_osc_run <= next_main_run;
      o_sub_osc_run <= next_sub_run;
    end
  end

  // Register writes and reads, read data valid one cycle later
  always_comb
  begin
    next_cpu_mode = cpu_mode;
    next_rdata = 8'h00;
    if (i_write && (i_addr == clk_pwr_pkg::CPU_MODE_ADDR))
      next_cpu_mode = i_wdata & clk_pwr_pkg::CPU_MODE_MASK;
    if (i_read)
    begin
      if (i_addr == clk_pwr_pkg::CPU_MODE_ADDR)
        next_rdata = cpu_mode;
      else if (i_addr == clk_pwr_pkg::CLK_STATUS_ADDR)
      begin
        next_rdata[clk_pwr_pkg::ST_MODE_LSB +: 2] = state;
        next_rdata[clk_pwr_pkg::ST_CPU_CLOCK_BIT] = o_cpu_clock;
        next_rdata[clk_pwr_pkg::ST_ACTIVE_SUB_BIT] = active_sub;
        next_rdata[clk_pwr_pkg::ST_MAIN_RUN_BIT] = o_main_osc_run;
        next_rdata[clk_pwr_pkg::ST_SUB_RUN_BIT] = o_sub_osc_run;
        next_rdata[clk_pwr_pkg::ST_WARMUP_BIT] = (state == clk_pwr_pkg::PWR_WARMUP);
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cpu_mode <= clk_pwr_pkg::CPU_MODE_RESET;
      o_rdata <= 8'h00;
    end
    else
    begin
      cpu_mode <= next_cpu_mode;
      o_rdata <= next_rdata;
    end
  end

  // Checks
  property p_wait_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
    (state == clk_pwr_pkg::PWR_WAIT) && o_cpu_clock && !wait_wake |=> o_cpu_clock;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("CPU clock fell in wait");

  property p_stop_osc_off;
    @(posedge i_sys_clk) disable iff (i_reset)
    (state == clk_pwr_pkg::PWR_STOP) && o_cpu_clock && !stop_wake |=>
      !o_main_osc_run && !o_sub_osc_run;
  endproperty
  a_stop_osc_off: assert property (p_stop_osc_off) else $error("Oscillator runs in stop");

  property p_main_halt;
    @(posedge i_sys_clk) disable iff (i_reset)
    cpu_mode[clk_pwr_pkg::MAIN_OSC_HALT_BIT] |=> !o_main_osc_run;
  endproperty
  a_main_halt: assert property (p_main_halt) else $error("Main osc runs while halted");

  property p_wait_release;
    @(posedge i_sys_clk) disable iff (i_reset)
    (state == clk_pwr_pkg::PWR_WAIT) && wait_wake |=>
      (state == clk_pwr_pkg::PWR_RUN) && o_resume_vector;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("Wait not released");

  property p_stop_ignores_t34;
    @(posedge i_sys_clk) disable iff (i_reset)
    (state == clk_pwr_pkg::PWR_STOP) && !stop_wake |=> (state == clk_pwr_pkg::PWR_STOP);
  endproperty
  a_stop_ignores_t34: assert property (p_stop_ignores_t34) else $error("Stop left");

  property p_warm_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
    (state == clk_pwr_pkg::PWR_STOP) ##1 (state == clk_pwr_pkg::PWR_WARMUP) |->
      o_cpu_clock throughout (state == clk_pwr_pkg::PWR_WARMUP)[*2];
  endproperty
  a_warm_hold: assert property (p_warm_hold) else $error("Clock ran in warm-up");

  property p_chain_load;
    @(posedge i_sys_clk) disable iff (i_reset)
    chain_load |=> (timer3 == clk_pwr_pkg::TIMER3_LOAD) && (timer4 == clk_pwr_pkg::TIMER4_LOAD);
  endproperty
  a_chain_load: assert property (p_chain_load) else $error("Warm-up chain not loaded");

  property p_stop_exit;
    @(posedge i_sys_clk) disable iff (i_reset)
    $rose(state == clk_pwr_pkg::PWR_RUN) && $past(state == clk_pwr_pkg::PWR_WARMUP) |->
      $past(chain_overflow) && o_resume_vector;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("Stop left without overflow");

  property p_switch_high;
    @(posedge i_sys_clk) disable iff (i_reset)
    $changed(active_sub) |-> $past(o_cpu_clock) && o_cpu_clock && $past(src_tick);
  endproperty
  a_switch_high: assert property (p_switch_high) else $error("Source switched while low");

endmodule

// file: verif/osc_pair_model.sv
module osc_pair_model #(
  parameter int MAIN_HALF = 5,
  parameter int SUB_HALF = 8
) (
  // Clock
  input wire logic i_sys_clk,
  // Oscillator enables from the block
  input wire logic i_main_run,
  input wire logic i_sub_run,
  // Oscillator pins
  output logic o_main_pin,
  output logic o_sub_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  int main_cnt = 0;
  int sub_cnt = 0;

  initial o_main_pin = 1'b0;
  initial o_sub_pin = 1'b0;

  // Each crystal swings only while enabled and stands still once halted
  always @(posedge i_sys_clk)
  begin
    if (i_main_run)
    begin
      main_cnt <= (main_cnt == MAIN_HALF - 1) ? 0 : main_cnt + 1;
      if (main_cnt == MAIN_HALF - 1)
        o_main_pin <= ~o_main_pin;
    end
    if (i_sub_run)
    begin
      sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
      if (sub_cnt == SUB_HALF - 1)
        o_sub_pin <= ~o_sub_pin;
    end
  end
endmodule

// file: verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MAIN_PER = 10;
  localparam int SUB_PER = 16;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic main_pin;
  logic sub_pin;
  logic main_run;
  logic sub_run;
  logic stop_i = 1'b0;
  logic wait_i = 1'b0;
  logic [8:0] irq = 9'h000;
  logic cpu_clock;
  logic resume;
  logic [8:0] wake_req;
  int n_errors = 0;
  int checks = 0;
  int phase = MAIN_PER;
  logic last_clk = 1'b1;

  // Free-running system clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  dual_osc_clock_power_control i_dual_osc_clock_power_control (
    .i_sys_clk(sys_clk),
    .i_reset(reset),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_write(wr),
    .i_read(rd),
    .o_rdata(rdata),
    .i_main_osc_in(main_pin),
    .i_sub_osc_in(sub_pin),
    .o_main_osc_run(main_run),
    .o_sub_osc_run(sub_run),
    .i_stop_instruction(stop_i),
    .i_wait_instruction(wait_i),
    .i_irq_req(irq),
    .o_cpu_clock(cpu_clock),
    .o_resume_vector(resume),
    .o_wake_requests(wake_req)
  );

  osc_pair_model #(.MAIN_HALF(MAIN_PER / 2), .SUB_HALF(SUB_PER / 2)) i_osc_pair_model (
    .i_sys_clk(sys_clk),
    .i_main_run(main_run),
    .i_sub_run(sub_run),
    .o_main_pin(main_pin),
    .o_sub_pin(sub_pin)
  );

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk_vec({1'b0, rdata & m}, {1'b0, e}, what);
  endtask

  // Counts cycles up to the next rising edge of the CPU clock, bounded
  task automatic wait_rise(input int lim, output int n);
    logic p;
    n = 0;
    do
    begin
      p = cpu_clock;
      @(posedge sys_clk);
      #1;
      n++;
      if (n > lim)
      begin
        n_errors++;
        $display("unexpected at %0t: clock timeout", $time);
        end_sim();
      end
    end
    while (!(p === 1'b0 && cpu_clock === 1'b1));
  endtask

  // One-cycle stop (stop_sel high) or wait instruction pulse
  task automatic hold_pulse(input bit stop_sel);
    @(posedge sys_clk);
    if (stop_sel)
      stop_i <= 1'b1;
    else
      wait_i <= 1'b1;
    @(posedge sys_clk);
    stop_i <= 1'b0;
    wait_i <= 1'b0;
  endtask

  task automatic check_period(input int per);
    int n;
    // Two rises let a pending source switch settle before the measured one
    wait_rise(200, n);
    wait_rise(200, n);
    wait_rise(200, n);
    chk_vec(9'(n), 9'(2 * per), "period");
  endtask

  // No phase of the CPU clock may be shorter than one fast source period
  always @(posedge sys_clk)
  begin
    if (reset)
      phase <= MAIN_PER;
    else if (cpu_clock !== last_clk)
    begin
      chk_bit(phase >= MAIN_PER, 1'b1, "short phase");
      phase <= 1;
    end
    else
      phase <= phase + 1;
    last_clk <= cpu_clock;
  end

  initial
  begin
    int n;
    logic bad;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_bit(main_run, 1'b1, "main run");
    chk_bit(sub_run, 1'b0, "sub run");
    rd_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'hff, 8'h00, "mode reset");
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hfb, 8'h10, "status reset");
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'h0f);
    rd_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'hff, 8'h00, "low bits");
    wr_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hff);
    wr_reg(8'h02, 8'hff);
    rd_reg(8'h02, 8'hff, 8'h00, "unmapped");
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hfb, 8'h10, "status ro");
    check_period(MAIN_PER);
    // Wait entry and release from every wake source; irq stands enabled
    for (int b = 0; b < clk_pwr_pkg::IRQ_COUNT; b++)
    begin
      hold_pulse(1'b0);
      repeat (20) @(posedge sys_clk);
      bad = 1'b0;
      repeat (40)
      begin
        @(posedge sys_clk);
        #1;
        if (cpu_clock !== 1'b1 || main_run !== 1'b1)
          bad = 1'b1;
      end
      chk_bit(bad, 1'b0, "wait hold");
      rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'h07, 8'h05, "wait state");
      @(posedge sys_clk);
      irq <= 9'h001 << b;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      while (resume !== 1'b1 && n < 4);
      chk_bit(resume, 1'b1, "wait wake");
      chk_vec(wake_req, 9'h001 << b, "wake vec");
      @(posedge sys_clk);
      irq <= 9'h000;
      wait_rise(2 * MAIN_PER + 6, n);
    end
    // Sub source start, switch, main halt and restart by program
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'h30);
    repeat (100) @(posedge sys_clk);
    chk_bit(sub_run, 1'b1, "sub start");
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'hb0);
    check_period(SUB_PER);
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hfb, 8'h38, "sub status");
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'hf0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(main_run, 1'b0, "main halt");
    check_period(SUB_PER);
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'hb0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(main_run, 1'b1, "main restart");
    repeat (100) @(posedge sys_clk);
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'h30);
    check_period(MAIN_PER);
    wr_reg(clk_pwr_pkg::CPU_MODE_ADDR, 8'h00);
    // Stop, refused timer wake, then warm-up
    hold_pulse(1'b1);
    repeat (40) @(posedge sys_clk);
    #1;
    chk_bit(main_run | sub_run, 1'b0, "osc stop");
    chk_bit(cpu_clock, 1'b1, "stop clock");
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hff, 8'h07, "stop state");
    @(posedge sys_clk);
    irq <= 9'h060;
    repeat (40) @(posedge sys_clk);
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hff, 8'h07, "timer wake");
    @(posedge sys_clk);
    irq <= 9'h061;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(main_run, 1'b1, "osc resume");
    chk_vec(wake_req, 9'h001, "stop wake");
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hff, 8'h56, "warmup");
    bad = 1'b0;
    repeat (3000)
    begin
      @(posedge sys_clk);
      #1;
      if (cpu_clock !== 1'b1 || resume !== 1'b0)
        bad = 1'b1;
    end
    chk_bit(bad, 1'b0, "warmup hold");
    @(posedge sys_clk);
    irq <= 9'h000;
    reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(clk_pwr_pkg::CLK_STATUS_ADDR, 8'hfb, 8'h10, "second reset");
    end_sim();
  end
endmodule
